/* File: src/lbx_bank.sv */
// module: link-b extra lane, sync word, ddc gain and over-range register bank
//
// Function
// - bits 7:1 enable link clocks lanes B1-B7
// - bit 0 also enables extra lane serializers
// - extra lanes follow link mode rate, framing
// - register-only lane with test 0/5 sends ramp
// - channel power-down overrides extra lane enables
// - serializer n needs lanes 0..n-1 enabled
// - bits 1:0 pick sync word, 64b/66b only
// - sync 0 CRC-12, 2 FEC, 1/3 reserved
// - command fields always sent as zero
// - gain bit doubles ddc filter output
// - I control bit at threshold zero, reset F2
// - threshold scaled as value over 256
// - Q control bit at threshold one, reset AB
`timescale 1ns/1ps
module lbx_bank (
   // clock and reset
   input  wire logic                               clk,
   input  wire logic                               rst_b,
   // register port
   input  wire logic                               reg_wr,
   input  wire logic [9:0]                         reg_addr,
   input  wire logic [7:0]                         reg_wdata,
   output logic      [7:0]                         reg_rdata,
   // link context from neighbouring registers
   input  wire logic                               serial_link_enable,
   input  wire logic                               channel_power_down,
   input  wire logic                               link_mode_is_64b66b,
   input  wire logic [lbx_pkg::LBX_NUM_LANES-1:0]  link_mode_lanes,
   input  wire logic [3:0]                         link_test_pattern_select,
   // lane controls
   output logic      [lbx_pkg::LBX_NUM_LANES-1:0]  lane_link_clk_en,
   output logic      [lbx_pkg::LBX_NUM_LANES-1:0]  lane_serializer_clk_en,
   output logic      [lbx_pkg::LBX_NUM_LANES-1:0]  lane_force_ramp,
   output logic      [3:0]                         lane_test_pattern,
   output logic                                    sync_fec_sel,
   output logic                                    sync_crc12_sel,
   output logic      [7:0]                         cmd_field,
   // ddc samples
   input  wire logic [lbx_pkg::LBX_SAMPLE_W-1:0]   ddc_i_in,
   input  wire logic [lbx_pkg::LBX_SAMPLE_W-1:0]   ddc_q_in,
   input  wire logic                               ddc_valid_in,
   output logic      [lbx_pkg::LBX_SAMPLE_W-1:0]   ddc_i_out,
   output logic      [lbx_pkg::LBX_SAMPLE_W-1:0]   ddc_q_out,
   output logic                                    ddc_valid_out,
   output logic                                    ovr_ctrl_i,
   output logic                                    ovr_ctrl_q
);
   import lbx_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]              extra_lane;
      logic [7:0]              sync_mode;
      logic [7:0]              gain_cfg;
      logic [7:0]              thr_zero;
      logic [7:0]              thr_one;
      logic [7:0]              rdata;
      logic [LBX_NUM_LANES-1:0] link_clk;
      logic [LBX_NUM_LANES-1:0] ser_clk;
      logic [LBX_NUM_LANES-1:0] ramp;
      logic                    fec;
      logic                    crc;
      logic [LBX_SAMPLE_W-1:0] i_out;
      logic [LBX_SAMPLE_W-1:0] q_out;
      logic                    vld;
      logic                    ovr_i;
      logic                    ovr_q;
   } lbx_state_s;

   lbx_state_s st_reg;
   lbx_state_s st_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [LBX_SAMPLE_W-1:0] lbx_boost(input logic [LBX_SAMPLE_W-1:0] s,
                                                      input logic en);
      logic [LBX_SAMPLE_W-1:0] r;
      logic                    ovf;
      r   = s;
      ovf = s[LBX_SAMPLE_W-1] ^ s[LBX_SAMPLE_W-2];
      if (en) begin
         // saturate rather than wrap: a wrapped sample looks like a full-scale flip
         if (ovf) begin
            r = s[LBX_SAMPLE_W-1] ? {1'b1, {(LBX_SAMPLE_W-1){1'b0}}}
                                  : {1'b0, {(LBX_SAMPLE_W-1){1'b1}}};
         end else begin
            r = {s[LBX_SAMPLE_W-2:0], 1'b0};
         end
      end
      return r;
   endfunction : lbx_boost

   // magnitude of the top eight bits, doubled: negative full scale gives 255, positive full scale 254
   function automatic logic [LBX_MAG_W-1:0] lbx_mag(input logic [LBX_SAMPLE_W-1:0] s);
      logic [LBX_MAG_W-1:0] t;
      logic [LBX_MAG_W-1:0] m;
      t = s[LBX_SAMPLE_W-1 -: LBX_MAG_W];
      m = t[LBX_MAG_W-1] ? LBX_MAG_W'(~t) : t;
      return LBX_MAG_W'({m, 1'b0} | {7'h00, t[LBX_MAG_W-1]}) ;
   endfunction : lbx_mag

   logic [LBX_NUM_LANES-1:0] extra_req;
   logic [LBX_NUM_LANES-1:0] lane_on;
   logic [LBX_NUM_LANES-1:0] chain_ok;
   logic [LBX_SAMPLE_W-1:0]  i_g;
   logic [LBX_SAMPLE_W-1:0]  q_g;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            LBX_OFS_EXTRA_LANE: st_next.extra_lane = reg_wdata;
            LBX_OFS_SYNC_MODE:  st_next.sync_mode  = reg_wdata;
            LBX_OFS_GAIN_CFG:   st_next.gain_cfg   = reg_wdata;
            LBX_OFS_THR_ZERO:   st_next.thr_zero   = reg_wdata;
            LBX_OFS_THR_ONE:    st_next.thr_one    = reg_wdata;
            default:            st_next.rdata      = st_reg.rdata;
         endcase
      end
      // read data, unmapped reads return zero
      case (reg_addr)
         LBX_OFS_EXTRA_LANE: st_next.rdata = st_next.extra_lane;
         LBX_OFS_SYNC_MODE:  st_next.rdata = st_next.sync_mode;
         LBX_OFS_GAIN_CFG:   st_next.rdata = st_next.gain_cfg;
         LBX_OFS_THR_ZERO:   st_next.rdata = st_next.thr_zero;
         LBX_OFS_THR_ONE:    st_next.rdata = st_next.thr_one;
         default:            st_next.rdata = 8'h00;
      endcase

      // lane enables: link mode lanes plus register lanes, lane 0 only from link mode
      extra_req = {st_reg.extra_lane[LBX_LANE_HI:LBX_LANE_LO], 1'b0};
      lane_on   = (channel_power_down == LBX_PD_OFF) ? (link_mode_lanes | extra_req)
                                                     : '0;
      st_next.link_clk = lane_on;
      // serializer clock ripples up from lane 0; one gap starves all lanes above
      chain_ok[0] = lane_on[0];
      for (int n = 1; n < LBX_NUM_LANES; n++) begin
         chain_ok[n] = chain_ok[n-1] & lane_on[n];
      end
      for (int n = 0; n < LBX_NUM_LANES; n++) begin
         st_next.ser_clk[n] = chain_ok[n] & serial_link_enable
                              & (link_mode_lanes[n]
                                 | st_reg.extra_lane[LBX_BIT_EXTRA_SER]);
         st_next.ramp[n] = lane_on[n] & ~link_mode_lanes[n]
                           & ((link_test_pattern_select == LBX_TEST_NONE)
                              | (link_test_pattern_select == LBX_TEST_ALT));
      end

      // sync word content, meaningful only in 64b/66b modes
      st_next.fec = link_mode_is_64b66b
                    & (st_reg.sync_mode[LBX_SYNC_MODE_HI:0] == LBX_SYNC_FEC);
      st_next.crc = link_mode_is_64b66b
                    & (st_reg.sync_mode[LBX_SYNC_MODE_HI:0] == LBX_SYNC_CRC12);

      // ddc gain and over-range control bits
      i_g = lbx_boost(ddc_i_in, st_reg.gain_cfg[LBX_BIT_BOOST]);
      q_g = lbx_boost(ddc_q_in, st_reg.gain_cfg[LBX_BIT_BOOST]);
      st_next.i_out = i_g;
      st_next.q_out = q_g;
      st_next.vld   = ddc_valid_in;
      // threshold compare on 8-bit magnitude, i.e. level = thr/256 of full scale
      st_next.ovr_i = ddc_valid_in & (lbx_mag(i_g) >= st_reg.thr_zero);
      st_next.ovr_q = ddc_valid_in & (lbx_mag(q_g) >= st_reg.thr_one);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg            <= '0;
         st_reg.extra_lane <= LBX_RST_EXTRA_LANE;
         st_reg.sync_mode  <= LBX_RST_SYNC_MODE;
         st_reg.gain_cfg   <= LBX_RST_GAIN_CFG;
         st_reg.thr_zero   <= LBX_RST_THR_ZERO;
         st_reg.thr_one    <= LBX_RST_THR_ONE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // extra lanes reuse the link-wide rate and pattern; no per-lane setting exists
   assign lane_test_pattern      = link_test_pattern_select;
   assign reg_rdata              = st_reg.rdata;
   assign lane_link_clk_en       = st_reg.link_clk;
   assign lane_serializer_clk_en = st_reg.ser_clk;
   assign lane_force_ramp        = st_reg.ramp;
   assign sync_fec_sel           = st_reg.fec;
   assign sync_crc12_sel         = st_reg.crc;
   assign cmd_field              = LBX_CMD_IDLE;
   assign ddc_i_out              = st_reg.i_out;
   assign ddc_q_out              = st_reg.q_out;
   assign ddc_valid_out          = st_reg.vld;
   assign ovr_ctrl_i             = st_reg.ovr_i;
   assign ovr_ctrl_q             = st_reg.ovr_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_pd_blocks_lanes: assert property (@(posedge clk) disable iff (!rst_b)
      channel_power_down |=> (lane_link_clk_en == '0))
      else $error("lanes active while channel powered down");

   a_lane_reg_clk: assert property (@(posedge clk) disable iff (!rst_b)
      (!channel_power_down && reg_wr && reg_addr == LBX_OFS_EXTRA_LANE && reg_wdata[3])
      ##1 !channel_power_down |=> lane_link_clk_en[3])
      else $error("extra lane link clock not enabled");

   a_ser_chain: assert property (@(posedge clk) disable iff (!rst_b)
      lane_serializer_clk_en[4] |-> (lane_link_clk_en[3:0] == 4'hF))
      else $error("serializer clocked with lower lane off");

   a_ser_needs_bit: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.extra_lane[LBX_BIT_EXTRA_SER] == 1'b0 && link_mode_lanes[5] == 1'b0)
      |=> !lane_serializer_clk_en[5])
      else $error("extra serializer on with select clear");

   a_ramp_force: assert property (@(posedge clk) disable iff (!rst_b)
      (lane_force_ramp[2]) |-> $past(link_test_pattern_select == LBX_TEST_NONE
                                     || link_test_pattern_select == LBX_TEST_ALT))
      else $error("ramp forced on wrong test pattern");

   a_sync_fec: assert property (@(posedge clk) disable iff (!rst_b)
      sync_fec_sel |-> $past(link_mode_is_64b66b) && !sync_crc12_sel)
      else $error("fec sync outside 64b66b mode");

   a_ovr_i_thr: assert property (@(posedge clk) disable iff (!rst_b)
      (ddc_valid_in
       && lbx_mag(lbx_boost(ddc_i_in, st_reg.gain_cfg[LBX_BIT_BOOST])) >= st_reg.thr_zero)
      |=> ovr_ctrl_i)
      else $error("i over-range bit missed");

   a_ovr_q_thr: assert property (@(posedge clk) disable iff (!rst_b)
      ovr_ctrl_q
      |-> $past(lbx_mag(lbx_boost(ddc_q_in, st_reg.gain_cfg[LBX_BIT_BOOST])) >= st_reg.thr_one))
      else $error("q over-range bit without level");

   a_readback: assert property (@(posedge clk) disable iff (!rst_b)
      (reg_wr && reg_addr == LBX_OFS_THR_ONE) ##1 (reg_addr == LBX_OFS_THR_ONE && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("readback mismatch");

   a_sync_outside: assert property (@(posedge clk) disable iff (!rst_b)
      !link_mode_is_64b66b |=> (!sync_fec_sel && !sync_crc12_sel))
      else $error("sync word selected outside 64b66b mode");

   a_sync_crc_code: assert property (@(posedge clk) disable iff (!rst_b)
      (link_mode_is_64b66b && st_reg.sync_mode[LBX_SYNC_MODE_HI:0] == LBX_SYNC_CRC12)
      |=> (sync_crc12_sel && !sync_fec_sel))
      else $error("crc-12 sync word not selected");

   a_sync_reserved: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.sync_mode[LBX_SYNC_MODE_HI:0] == LBX_SYNC_RSV1
       || st_reg.sync_mode[LBX_SYNC_MODE_HI:0] == LBX_SYNC_RSV3)
      |=> (!sync_fec_sel && !sync_crc12_sel))
      else $error("reserved sync code selected a sync word");

   a_cmd_idle: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_field == LBX_CMD_IDLE)
      else $error("command field not idle");

   a_test_follow: assert property (@(posedge clk) disable iff (!rst_b)
      lane_test_pattern == link_test_pattern_select)
      else $error("lane test pattern differs from link setting");

   a_gain_unity: assert property (@(posedge clk) disable iff (!rst_b)
      !st_reg.gain_cfg[LBX_BIT_BOOST]
      |=> (ddc_i_out == $past(ddc_i_in) && ddc_q_out == $past(ddc_q_in)))
      else $error("sample changed with unity gain");

   a_gain_double: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.gain_cfg[LBX_BIT_BOOST]
       && ddc_i_in[LBX_SAMPLE_W-1] == ddc_i_in[LBX_SAMPLE_W-2])
      |=> ddc_i_out == {$past(ddc_i_in[LBX_SAMPLE_W-2:0]), 1'b0})
      else $error("boosted sample not doubled");

   a_ovr_refused: assert property (@(posedge clk) disable iff (!rst_b)
      !ddc_valid_in |=> (!ovr_ctrl_i && !ovr_ctrl_q))
      else $error("over-range bit set on invalid sample");

   a_lane0_mode: assert property (@(posedge clk) disable iff (!rst_b)
      !link_mode_lanes[0] |=> !lane_link_clk_en[0])
      else $error("lane zero enabled without link mode");

   a_ramp_mode_lane: assert property (@(posedge clk) disable iff (!rst_b)
      link_mode_lanes[1] |=> !lane_force_ramp[1])
      else $error("ramp forced on link mode lane");
endmodule : lbx_bank

/* File: src/lbx_pkg.sv */
// package: register map, field layout and encodings of the link-b lane / ddc / over-range bank
package lbx_pkg;
   // ----------------------------------------------------------------
   // register offsets (10-bit register port address)
   // ----------------------------------------------------------------
   localparam logic [9:0] LBX_OFS_EXTRA_LANE = 10'h20B;
   localparam logic [9:0] LBX_OFS_SYNC_MODE  = 10'h20F;
   localparam logic [9:0] LBX_OFS_GAIN_CFG   = 10'h210;
   localparam logic [9:0] LBX_OFS_THR_ZERO   = 10'h211;
   localparam logic [9:0] LBX_OFS_THR_ONE    = 10'h212;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] LBX_RST_EXTRA_LANE = 8'h00;
   localparam logic [7:0] LBX_RST_SYNC_MODE  = 8'h00;
   localparam logic [7:0] LBX_RST_GAIN_CFG   = 8'h00;
   localparam logic [7:0] LBX_RST_THR_ZERO   = 8'hF2;
   localparam logic [7:0] LBX_RST_THR_ONE    = 8'hAB;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int LBX_BIT_EXTRA_SER  = 0;
   localparam int LBX_LANE_LO        = 1;
   localparam int LBX_LANE_HI        = 7;
   localparam int LBX_NUM_LANES      = 8;
   localparam int LBX_BIT_BOOST      = 0;
   localparam int LBX_SYNC_MODE_HI   = 1;
   localparam int LBX_SAMPLE_W       = 16;
   localparam int LBX_MAG_W          = 8;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LBX_SYNC_CRC12 = 2'b00,
      LBX_SYNC_RSV1  = 2'b01,
      LBX_SYNC_FEC   = 2'b10,
      LBX_SYNC_RSV3  = 2'b11
   } lbx_sync_e;

   localparam logic [3:0] LBX_TEST_NONE  = 4'h0;
   localparam logic [3:0] LBX_TEST_RAMP  = 4'h4;
   localparam logic [3:0] LBX_TEST_ALT   = 4'h5;
   localparam logic [7:0] LBX_CMD_IDLE   = 8'h00;
   localparam logic       LBX_PD_OFF     = 1'b0;
endpackage : lbx_pkg

/* File: dv/link_b_lanes_ddc_overrange_cfg_tb.sv */
// testbench: register bank, lane controls, sync word and ddc over-range checks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module link_b_lanes_ddc_overrange_cfg_tb;
   import lbx_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clk = 0, rst_b = 0, reg_wr = 0, en = 0, pd = 0, m64 = 0, vin = 0;
   logic [9:0]  addr = '0;
   logic [7:0]  wdata = '0, rdata, ml = '0, lk, ser, rmp, cmd;
   logic [3:0]  tp = '0, tp_out;
   logic [15:0] iin = '0, qin = '0, iout, qout;
   logic        vout, oi, oq, fec, crc, rd_pend = 0, rd_seen = 0;
   logic [7:0]  t0, t1, ext, v8;
   logic        boost;
   logic [7:0]  reg_q[$];
   logic [33:0] smp_q[$];
   int          err_count = 0, n_checks = 0, cyc = 0;
   always #2 clk = ~clk;
   lbx_bank dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .serial_link_enable(en),
      .channel_power_down(pd), .link_mode_is_64b66b(m64), .link_mode_lanes(ml),
      .link_test_pattern_select(tp), .lane_link_clk_en(lk), .lane_serializer_clk_en(ser),
      .lane_force_ramp(rmp), .lane_test_pattern(tp_out), .sync_fec_sel(fec),
      .sync_crc12_sel(crc), .cmd_field(cmd), .ddc_i_in(iin), .ddc_q_in(qin),
      .ddc_valid_in(vin), .ddc_i_out(iout), .ddc_q_out(qout), .ddc_valid_out(vout),
      .ovr_ctrl_i(oi), .ovr_ctrl_q(oq));
   // ----------------------------------------------------------------
   // models and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [7:0] mag(logic [15:0] x);
      logic [7:0] m;
      m = x[15] ? ~x[15:8] : x[15:8];
      return {m[6:0], x[15]};
   endfunction : mag
   function automatic logic [15:0] dbl(logic [15:0] x);
      if (x[15] != x[14]) return x[15] ? 16'h8000 : 16'h7FFF;
      return {x[14:0], 1'b0};
   endfunction : dbl
   task automatic wr(logic [9:0] a, logic [7:0] d);
      @(negedge clk);
      rd_pend = 0; reg_wr = 1; addr = a; wdata = d;
      if (a == LBX_OFS_THR_ZERO) t0 = d;
      if (a == LBX_OFS_THR_ONE) t1 = d;
      if (a == LBX_OFS_GAIN_CFG) boost = d[LBX_BIT_BOOST];
   endtask : wr
   task automatic rd(logic [9:0] a, logic [7:0] e);
      @(negedge clk);
      reg_wr = 0; addr = a; rd_pend = 1;
      reg_q.push_back(e);
   endtask : rd
   task automatic smp(logic [15:0] i, logic [15:0] q, logic v);
      logic [15:0] ei, eq;
      @(negedge clk);
      reg_wr = 0; rd_pend = 0; iin = i; qin = q; vin = v;
      ei = boost ? dbl(i) : i;
      eq = boost ? dbl(q) : q;
      // thresholds apply to the output samples, after any gain
      if (v) smp_q.push_back({mag(eq) >= t1, mag(ei) >= t0, ei, eq});
   endtask : smp
   // ----------------------------------------------------------------
   // watcher: takes the oldest note whenever a result appears
   // ----------------------------------------------------------------
   always @(posedge clk) rd_seen <= rd_pend;
   always @(negedge clk) begin
      if (rd_seen) begin
         if (reg_q.size() == 0) `CHK("read note", 1'b1, 1'b0)
         else `CHK("reg_rdata", reg_q.pop_front(), rdata)
      end
      if (vout === 1'b1) begin
         if (smp_q.size() == 0) `CHK("sample note", 1'b1, 1'b0)
         else `CHK("ovr and samples", smp_q.pop_front(), {oq, oi, iout, qout})
      end else begin
         `CHK("ovr when idle", 2'b00, {oq, oi})
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin err_count++; summarize(); end
   end
   task automatic defaults();
      t0 = LBX_RST_THR_ZERO; t1 = LBX_RST_THR_ONE; boost = 0;
      rd(LBX_OFS_EXTRA_LANE, 8'h00); rd(LBX_OFS_SYNC_MODE, 8'h00);
      rd(LBX_OFS_GAIN_CFG, 8'h00); rd(LBX_OFS_THR_ZERO, 8'hF2);
      rd(LBX_OFS_THR_ONE, 8'hAB); rd(10'h20C, 8'h00);
   endtask : defaults
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   logic [7:0] lk_e, ser_e, rmp_e;
   logic       acc;
   initial begin
      void'($urandom(32'h6CA359F3));
      repeat (12) @(negedge clk);
      rst_b = 1;
      defaults();
      $display("test reset values done");
      // back-to-back writes, reserved bits kept, unmapped write ignored
      for (int k = 0; k < 8; k++) begin
         v8 = $urandom;
         wr(LBX_OFS_EXTRA_LANE + 10'(k % 2) * 4, v8); wr(10'h20D, 8'hFF);
         rd(LBX_OFS_EXTRA_LANE + 10'(k % 2) * 4, v8); rd(10'h20D, 8'h00);
      end
      $display("test readback done");
      // every sync code, with and without 64b/66b
      for (int k = 0; k < 8; k++) begin
         wr(LBX_OFS_SYNC_MODE, {6'h2A, 2'(k)});
         @(negedge clk); reg_wr = 0; m64 = k[2];
         @(negedge clk);
         `CHK("fec sel", k[2] && k[1:0] == 2, fec)
         `CHK("crc sel", k[2] && k[1:0] == 0, crc)
         `CHK("cmd field", LBX_CMD_IDLE, cmd)
      end
      $display("test sync word done");
      // random lane set-ups, test codes cycled through
      for (int k = 0; k < 48; k++) begin
         ext = $urandom;
         wr(LBX_OFS_EXTRA_LANE, ext);
         @(negedge clk);
         reg_wr = 0; en = $urandom; pd = ($urandom % 4) == 0; ml = $urandom; tp = 4'(k % 8);
         if (k % 3 == 0) ml = 8'h01;
         acc = 1;
         for (int n = 0; n < LBX_NUM_LANES; n++) begin
            lk_e[n] = !pd && (ml[n] || (n > 0 && ext[n]));
            acc = acc && lk_e[n];
            ser_e[n] = acc && en && (ml[n] || ext[LBX_BIT_EXTRA_SER]);
            rmp_e[n] = lk_e[n] && !ml[n] && (tp == LBX_TEST_NONE || tp == LBX_TEST_ALT);
         end
         @(negedge clk);
         `CHK("lane link clk", lk_e, lk)
         `CHK("lane serializer", ser_e, ser)
         `CHK("lane ramp", rmp_e, rmp)
         `CHK("lane test", tp, tp_out)
         // link disabled again before the next lane register change
         en = 0;
      end
      en = 0;
      $display("test lanes done");
      // thresholds placed at and just above each sample's magnitude
      for (int k = 0; k < 24; k++) begin
         iin = 16'($urandom); qin = 16'($urandom);
         wr(LBX_OFS_THR_ZERO, mag(iin) + 8'($urandom % 2));
         wr(LBX_OFS_THR_ONE, mag(qin) + 8'($urandom % 2));
         smp(iin, qin, 1);
         smp(16'h7FFF, 16'h8000, 1);
         // full-scale but invalid: control bits must stay clear
         smp(16'h7FFF, 16'h8000, 0);
      end
      $display("test over-range done");
      // gain doubling with saturation, thresholds kept high
      wr(LBX_OFS_THR_ZERO, 8'hFF); wr(LBX_OFS_THR_ONE, 8'hFF);
      for (int k = 0; k < 2; k++) begin
         // image taken as filtered out by the down-converter here
         wr(LBX_OFS_GAIN_CFG, {7'h55, 1'(k)});
         smp(16'h00F3, 16'hFF07, 1); smp(16'h5000, 16'hA000, 1);
         for (int j = 0; j < 6; j++) smp(16'($urandom), 16'($urandom), 1);
         smp(16'h0000, 16'h0000, 0);
      end
      $display("test gain done");
      // reset in mid-run reloads defaults
      wr(LBX_OFS_THR_ONE, 8'h12);
      @(negedge clk); rst_b = 0; reg_wr = 0;
      repeat (2) @(negedge clk);
      rst_b = 1;
      defaults();
      smp(16'h7FFF, 16'h0000, 1); smp(16'h0000, 16'h0000, 0);
      repeat (3) @(negedge clk);
      // every noted result must have been seen
      `CHK("notes left", 0, reg_q.size() + smp_q.size())
      $display("test second reset done");
      summarize();
   end
endmodule : link_b_lanes_ddc_overrange_cfg_tb
